// File: tpg_regs.svh
// Purpose: register offsets and reset values of the three port gpio block
// Assumes: byte-wide register bus, 8-bit byte addresses
// Notes: offsets of port one drain, pullup and mode registers are local
`ifndef TPG_REGS_SVH
`define TPG_REGS_SVH
`define TPG_ADDR_P0_DATA 8'hc0
`define TPG_ADDR_P0_DIR 8'hc1
`define TPG_ADDR_P1_DATA 8'hc2
`define TPG_ADDR_P1_DIR 8'hc3
`define TPG_ADDR_P2_DATA 8'hc4
`define TPG_ADDR_P2_DIR 8'hc5
`define TPG_ADDR_P1_FUNC 8'hc9
`define TPG_ADDR_P1_DRAIN 8'hde
`define TPG_ADDR_P2_DRAIN 8'hdf
`define TPG_ADDR_P0_DRAIN 8'he4
`define TPG_ADDR_P0_PULL 8'hf8
`define TPG_ADDR_P1_PULL 8'hf9
`define TPG_ADDR_P2_PULL 8'hfa
`define TPG_CTRL_RESET 8'h00
`define TPG_READ_ZERO 8'h00
`define TPG_P2_MASK 8'h1f
`define TPG_P1_LSB 8
`define TPG_P0_PINS 8
`define TPG_P1_PINS 8
`define TPG_P2_PINS 5
`define TPG_BIT_T0 7
`define TPG_BIT_T1 6
`define TPG_BIT_T2 5
`define TPG_BIT_EC 4
`define TPG_BIT_IRQ2 2
`define TPG_BIT_IRQ1 1
`endif

// File: tpg_pkg.sv
// Purpose: types of the three port gpio block
// Assumes: nothing beyond the register header
// Notes: one state struct holds every flip-flop
package tpg_pkg;
  typedef struct packed {
    logic [7:0] p0_data;
    logic [7:0] p1_data;
    logic [4:0] p2_data;
    logic [7:0] p0_dir;
    logic [7:0] p1_dir;
    logic [4:0] p2_dir;
    logic [7:0] p0_od;
    logic [7:0] p1_od;
    logic [4:0] p2_od;
    logic [7:0] p0_pu;
    logic [7:0] p1_pu;
    logic [4:0] p2_pu;
    logic [7:0] p1_func;
    logic [20:0] pin_s1;
    logic [20:0] pin_s2;
    logic [20:0] oe;
    logic [20:0] dout;
    logic [20:0] pull;
    logic [7:0] rdata;
    logic ec;
    logic irq1;
    logic irq2;
  } tpg_state_t;
endpackage

// File: tpg_gpio.sv
// Purpose: three bidirectional ports with pin drive, pullup and pin mux
// Assumes: byte register bus, pins sampled by two flip-flops
// Notes: pad resolves the wire from oe and dout; pull asks for a pullup
`timescale 1ns/100ps
`include "tpg_regs.svh"
module tpg_gpio #(
  // port widths; the register map only serves 8, 8 and 5
  parameter int P0_W = 8,
  parameter int P1_W = 8,
  parameter int P2_W = 5
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // pins, bit 20..16 port two, 15..8 port one, 7..0 port zero
  input wire logic [20:0] pin_in,
  output logic [20:0] pin_out,
  output logic [20:0] pin_oe_out,
  output logic [20:0] pull_en_out,
  // alternate function sources and sinks
  input wire logic timer_zero_output_in,
  input wire logic timer_one_output_in,
  input wire logic timer_two_output_in,
  output logic event_count_input_out,
  output logic external_irq_one_out,
  output logic external_irq_two_out
);
  tpg_pkg::tpg_state_t s_r;
  tpg_pkg::tpg_state_t s_nxt;
  logic [20:0] dir_all;
  logic [20:0] od_all;
  logic [20:0] pu_all;
  logic [20:0] dat_all;
  logic [20:0] alt_oe;
  logic [20:0] alt_val;
  // total pin count, kept as a name so loops carry no bare width
  localparam int N_PINS = P0_W + P1_W + P2_W;

  // refuse port widths that the fixed byte map cannot serve
  if (P0_W != `TPG_P0_PINS || P1_W != `TPG_P1_PINS ||
      P2_W != `TPG_P2_PINS) begin : g_width_check
    $error("tpg_gpio: unsupported port widths");
  end

  // flatten per-port registers onto the pin vector
  assign dir_all = {s_r.p2_dir, s_r.p1_dir, s_r.p0_dir};
  assign od_all = {s_r.p2_od, s_r.p1_od, s_r.p0_od};
  assign pu_all = {s_r.p2_pu, s_r.p1_pu, s_r.p0_pu};
  assign dat_all = {s_r.p2_data, s_r.p1_data, s_r.p0_data};

  // alternate outputs on port one; other pins keep plain io
  always_comb begin
    alt_oe = '0;
    alt_val = '0;
    alt_oe[`TPG_P1_LSB + `TPG_BIT_T0] = s_r.p1_func[`TPG_BIT_T0];
    alt_oe[`TPG_P1_LSB + `TPG_BIT_T1] = s_r.p1_func[`TPG_BIT_T1];
    alt_oe[`TPG_P1_LSB + `TPG_BIT_T2] = s_r.p1_func[`TPG_BIT_T2];
    alt_val[`TPG_P1_LSB + `TPG_BIT_T0] = timer_zero_output_in;
    alt_val[`TPG_P1_LSB + `TPG_BIT_T1] = timer_one_output_in;
    alt_val[`TPG_P1_LSB + `TPG_BIT_T2] = timer_two_output_in;
  end

  // next state: bus writes, pin sampling and registered pad controls
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_s1 = pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.rdata = `TPG_READ_ZERO;
    if (wr_in) begin
      // whole-byte writes only; bit operations are not supported
      case (addr_in)
        `TPG_ADDR_P0_DATA: s_nxt.p0_data = wdata_in;
        `TPG_ADDR_P1_DATA: s_nxt.p1_data = wdata_in;
        `TPG_ADDR_P2_DATA: s_nxt.p2_data = wdata_in[4:0];
        `TPG_ADDR_P0_DIR: s_nxt.p0_dir = wdata_in;
        `TPG_ADDR_P1_DIR: s_nxt.p1_dir = wdata_in;
        `TPG_ADDR_P2_DIR: s_nxt.p2_dir = wdata_in[4:0];
        `TPG_ADDR_P0_DRAIN: s_nxt.p0_od = wdata_in;
        `TPG_ADDR_P1_DRAIN: s_nxt.p1_od = wdata_in;
        `TPG_ADDR_P2_DRAIN: s_nxt.p2_od = wdata_in[4:0];
        `TPG_ADDR_P0_PULL: s_nxt.p0_pu = wdata_in;
        `TPG_ADDR_P1_PULL: s_nxt.p1_pu = wdata_in;
        `TPG_ADDR_P2_PULL: s_nxt.p2_pu = wdata_in[4:0];
        `TPG_ADDR_P1_FUNC: s_nxt.p1_func = wdata_in;
        default: s_nxt.rdata = `TPG_READ_ZERO;
      endcase
    end
    if (rd_in) begin
      // write-only registers and unmapped addresses read zero
      case (addr_in)
        `TPG_ADDR_P0_DATA:
          s_nxt.rdata = (s_r.p0_dir & s_r.p0_data) |
                        (~s_r.p0_dir & s_r.pin_s2[7:0]);
        `TPG_ADDR_P1_DATA:
          s_nxt.rdata = (s_r.p1_dir & s_r.p1_data) |
                        (~s_r.p1_dir & s_r.pin_s2[15:8]);
        `TPG_ADDR_P2_DATA:
          s_nxt.rdata = {3'h0, (s_r.p2_dir & s_r.p2_data) |
                        (~s_r.p2_dir & s_r.pin_s2[20:16])};
        default: s_nxt.rdata = `TPG_READ_ZERO;
      endcase
    end
    // pad drive: alternate outputs always push-pull; otherwise open drain drives only low, else push-pull
    for (int i = 0; i < N_PINS; i++) begin
      if (alt_oe[i]) begin
        s_nxt.oe[i] = 1'b1;
        s_nxt.dout[i] = alt_val[i];
      end else begin
        s_nxt.oe[i] = dir_all[i] & (~od_all[i] | ~dat_all[i]);
        s_nxt.dout[i] = dat_all[i];
      end
      // pullup only on inputs with control bit zero
      s_nxt.pull[i] = ~dir_all[i] & ~alt_oe[i] & ~pu_all[i];
    end
    // alternate inputs see the synchronised pin level
    s_nxt.ec = s_r.p1_func[`TPG_BIT_EC] &
               s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_EC];
    s_nxt.irq1 = s_r.p1_func[`TPG_BIT_IRQ1] &
                 s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_IRQ1];
    s_nxt.irq2 = s_r.p1_func[`TPG_BIT_IRQ2] &
                 s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_IRQ2];
  end

  // data registers are reset too so pins stay defined; software must
  // still not rely on their value after reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.p0_dir <= `TPG_CTRL_RESET;
      s_r.p1_dir <= `TPG_CTRL_RESET;
      s_r.p0_od <= `TPG_CTRL_RESET;
      s_r.p0_pu <= `TPG_CTRL_RESET;
      s_r.p1_func <= `TPG_CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign pin_out = s_r.dout;
  assign pin_oe_out = s_r.oe;
  assign pull_en_out = s_r.pull;
  assign event_count_input_out = s_r.ec;
  assign external_irq_one_out = s_r.irq1;
  assign external_irq_two_out = s_r.irq2;

  // pad state straight after reset
  a_dir_reset_input: assert property (
    @(posedge clk_in)
    $fell(rst_in) |-> pin_oe_out == '0)
    else $error("pins not inputs after reset");

  a_pull_after_reset: assert property (
    @(posedge clk_in)
    $fell(rst_in) |=> pull_en_out == '1)
    else $error("pullups not on after reset");

  // pad drive and pullup
  a_pull_off_out: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (pin_oe_out & pull_en_out) == '0)
    else $error("pullup on driven pin");

  a_od_no_high: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (pin_oe_out & pin_out & od_all & ~alt_oe) == '0)
    else $error("open drain drove high");

  a_out_drive: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P0_DATA && s_r.p0_dir == 8'hff &&
    s_r.p0_od == 8'h00 ##1 !wr_in |=> pin_out[7:0] == $past(s_r.p0_data))
    else $error("output data not driven");

  // per pin: input, push-pull and open-drain drive, pullup
  for (genvar g = 0; g < N_PINS; g++) begin : g_pin_chk
    a_in_no_drive: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !alt_oe[g] && !dir_all[g] |=> !pin_oe_out[g])
      else $error("input pin driven");

    a_pp_drive: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !alt_oe[g] && dir_all[g] && !od_all[g] |=> pin_oe_out[g])
      else $error("push-pull pin not driven");

    a_od_release: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !alt_oe[g] && od_all[g] && dat_all[g] |=> !pin_oe_out[g])
      else $error("open drain pin drove high");

    a_in_pull: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !alt_oe[g] && !dir_all[g] |=> pull_en_out[g] == !$past(pu_all[g]))
      else $error("pullup control not applied");
  end

  // register bus reads
  a_p2_upper_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $past(rd_in) && $past(addr_in) == `TPG_ADDR_P2_DATA
    |-> rdata_out[7:5] == 3'h0)
    else $error("port two upper bits not zero");

  a_wo_read_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == `TPG_ADDR_P0_DIR |=> rdata_out == `TPG_READ_ZERO)
    else $error("direction read nonzero");

  a_wo_func_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == `TPG_ADDR_P1_FUNC |=> rdata_out == `TPG_READ_ZERO)
    else $error("mode read nonzero");

  a_wo_drain_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == `TPG_ADDR_P0_DRAIN |=> rdata_out == `TPG_READ_ZERO)
    else $error("drain select read nonzero");

  a_wo_pull_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == `TPG_ADDR_P0_PULL |=> rdata_out == `TPG_READ_ZERO)
    else $error("pullup control read nonzero");

  a_in_read: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_in && addr_in == `TPG_ADDR_P1_DATA && s_r.p1_dir == 8'h00
    |=> rdata_out == $past(s_r.pin_s2[15:8]))
    else $error("input level not read");

  // register writes land whole
  a_wr_p0_data: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P0_DATA |=> s_r.p0_data == $past(wdata_in))
    else $error("port zero data write lost");

  a_wr_p1_data: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P1_DATA |=> s_r.p1_data == $past(wdata_in))
    else $error("port one data write lost");

  a_wr_p2_data: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P2_DATA
    |=> s_r.p2_data == $past(wdata_in[4:0]))
    else $error("port two data write lost");

  a_wr_p0_dir: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P0_DIR |=> s_r.p0_dir == $past(wdata_in))
    else $error("port zero direction write lost");

  a_wr_p1_dir: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P1_DIR |=> s_r.p1_dir == $past(wdata_in))
    else $error("port one direction write lost");

  a_wr_p2_dir: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P2_DIR
    |=> s_r.p2_dir == $past(wdata_in[4:0]))
    else $error("port two direction write lost");

  a_wr_p0_od: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P0_DRAIN |=> s_r.p0_od == $past(wdata_in))
    else $error("port zero drain write lost");

  a_wr_p1_od: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P1_DRAIN |=> s_r.p1_od == $past(wdata_in))
    else $error("port one drain write lost");

  a_wr_p2_od: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P2_DRAIN
    |=> s_r.p2_od == $past(wdata_in[4:0]))
    else $error("port two drain write lost");

  a_wr_p0_pu: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P0_PULL |=> s_r.p0_pu == $past(wdata_in))
    else $error("port zero pullup write lost");

  a_wr_p1_pu: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P1_PULL |=> s_r.p1_pu == $past(wdata_in))
    else $error("port one pullup write lost");

  a_wr_p2_pu: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P2_PULL
    |=> s_r.p2_pu == $past(wdata_in[4:0]))
    else $error("port two pullup write lost");

  a_wr_func: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_in && addr_in == `TPG_ADDR_P1_FUNC |=> s_r.p1_func == $past(wdata_in))
    else $error("mode write lost");

  // pin multiplexer on port one
  a_timer_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_T0] |=> pin_oe_out[`TPG_P1_LSB + `TPG_BIT_T0] &&
    pin_out[`TPG_P1_LSB + `TPG_BIT_T0] == $past(timer_zero_output_in))
    else $error("timer zero not on pin");

  a_timer_one_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_T1] |=> pin_oe_out[`TPG_P1_LSB + `TPG_BIT_T1] &&
    pin_out[`TPG_P1_LSB + `TPG_BIT_T1] == $past(timer_one_output_in))
    else $error("timer one not on pin");

  a_timer_two_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_T2] |=> pin_oe_out[`TPG_P1_LSB + `TPG_BIT_T2] &&
    pin_out[`TPG_P1_LSB + `TPG_BIT_T2] == $past(timer_two_output_in))
    else $error("timer two not on pin");

  a_irq_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !s_r.p1_func[`TPG_BIT_IRQ1] |=> !external_irq_one_out)
    else $error("irq seen in port mode");

  a_ec_port_mode: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !s_r.p1_func[`TPG_BIT_EC] |=> !event_count_input_out)
    else $error("event count seen in port mode");

  a_irq2_port_mode: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !s_r.p1_func[`TPG_BIT_IRQ2] |=> !external_irq_two_out)
    else $error("irq two seen in port mode");

  a_ec_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_EC] |=> event_count_input_out ==
    $past(s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_EC]))
    else $error("event count not routed");

  a_irq1_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_IRQ1] |=> external_irq_one_out ==
    $past(s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_IRQ1]))
    else $error("irq one not routed");

  a_irq2_route: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_r.p1_func[`TPG_BIT_IRQ2] |=> external_irq_two_out ==
    $past(s_r.pin_s2[`TPG_P1_LSB + `TPG_BIT_IRQ2]))
    else $error("irq two not routed");

  // main scenarios
  c_alt_mode: cover property (@(posedge clk_in) s_r.p1_func != 8'h00);
  c_od_low: cover property (@(posedge clk_in) (pin_oe_out & od_all) != '0);
  c_read_pin: cover property (@(posedge clk_in) rd_in && !rst_in);
  c_irq_in: cover property (@(posedge clk_in) external_irq_two_out);
  c_timer_pin: cover property (@(posedge clk_in) pin_oe_out[15] && pin_out[15]);
endmodule

// File: tpg_pad_model.sv
// Purpose: board model of the 21 pads on the gpio block
// Assumes: device drive wins over board drive
// Notes: a floating pad flips each cycle so no stale level passes
`timescale 1ns/100ps
module tpg_pad_model (
  // clock
  input wire logic clk_in,
  // device side
  input wire logic [20:0] oe_in,
  input wire logic [20:0] dout_in,
  input wire logic [20:0] pull_in,
  // board side
  input wire logic [20:0] ext_en_in,
  input wire logic [20:0] ext_val_in,
  output logic [20:0] lvl_out
);
  logic [20:0] last_r = 21'h0;
  // resolve each pad from every driver and the pullup
  always_comb begin
    for (int i = 0; i < 21; i++) begin
      if (oe_in[i]) lvl_out[i] = dout_in[i];
      else if (ext_en_in[i]) lvl_out[i] = ext_val_in[i];
      else if (pull_in[i]) lvl_out[i] = 1'h1;
      else lvl_out[i] = ~last_r[i];
    end
  end
  // last level, used only for floating pads
  always_ff @(posedge clk_in) last_r <= lvl_out;
endmodule

// File: tb.sv
// Purpose: self-checking bench of the three port gpio block
// Assumes: 10 MHz clock, board pads modelled apart
// Notes: data registers are never checked straight after reset
`timescale 1ns/100ps
`include "tpg_regs.svh"
module tb;
  logic clk_in = 1'h0, rst_in = 1'h1, wr = 1'h0, rd = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [20:0] lvl, dout, oe, pull, ext_en = 21'h0, ext_val = 21'h0;
  logic t0 = 1'h0, t1 = 1'h0, t2 = 1'h0, ec, irq1, irq2;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  tpg_gpio u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .pin_in(lvl), .pin_out(dout), .pin_oe_out(oe), .pull_en_out(pull),
    .timer_zero_output_in(t0), .timer_one_output_in(t1),
    .timer_two_output_in(t2), .event_count_input_out(ec),
    .external_irq_one_out(irq1), .external_irq_two_out(irq2));
  tpg_pad_model u_pad (.clk_in(clk_in), .oe_in(oe), .dout_in(dout),
    .pull_in(pull), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .lvl_out(lvl));
  initial forever #50 clk_in = ~clk_in;
  // a hang is cut short well past the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // whole-byte write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a; wdata <= d; wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a; rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    #1 chk({13'h0, rdata}, {13'h0, exp});
  endtask
  task automatic t_reset();
    chk(oe, 21'h0);
    chk(pull, 21'h1fffff);
    rd_chk(`TPG_ADDR_P0_DRAIN, 8'h00);
    rd_chk(`TPG_ADDR_P0_DIR, 8'h00);
    rd_chk(`TPG_ADDR_P1_FUNC, 8'h00);
    rd_chk(`TPG_ADDR_P0_PULL, 8'h00);
  endtask
  task automatic t_out0();
    wr_reg(`TPG_ADDR_P0_DIR, 8'hff);
    wr_reg(`TPG_ADDR_P0_DATA, 8'ha5);
    wr_reg(`TPG_ADDR_P0_PULL, 8'h00);
    chk({13'h0, oe[7:0]}, 21'hff);
    chk({13'h0, dout[7:0]}, 21'ha5);
    chk({13'h0, pull[7:0]}, 21'h0);
    rd_chk(`TPG_ADDR_P0_DATA, 8'ha5);
    rd_chk(`TPG_ADDR_P0_DIR, 8'h00);
  endtask
  task automatic t_in1();
    ext_en[15:8] <= 8'hff;
    ext_val[15:8] <= 8'h3c;
    wr_reg(`TPG_ADDR_P1_PULL, 8'h0f);
    rd_chk(`TPG_ADDR_P1_DATA, 8'h3c);
    chk({13'h0, pull[15:8]}, 21'hf0);
  endtask
  task automatic t_drain2();
    wr_reg(`TPG_ADDR_P2_DIR, 8'hff);
    wr_reg(`TPG_ADDR_P2_DRAIN, 8'hff);
    wr_reg(`TPG_ADDR_P2_DATA, 8'hea);
    chk({16'h0, oe[20:16]}, 21'h15);
    chk({16'h0, dout[20:16]}, 21'h0a);
    rd_chk(`TPG_ADDR_P2_DATA, 8'h0a);
    wr_reg(`TPG_ADDR_P2_DRAIN, 8'h00);
    chk({16'h0, oe[20:16]}, 21'h1f);
  endtask
  task automatic t_alt1();
    t0 <= 1'h1; t2 <= 1'h1;
    wr_reg(`TPG_ADDR_P1_FUNC, 8'hff);
    chk({18'h0, oe[15:13]}, 21'h7);
    chk({18'h0, dout[15:13]}, 21'h5);
    chk({13'h0, pull[15:8]}, 21'h10);
    chk({18'h0, ec, irq2, irq1}, 21'h6);
    wr_reg(`TPG_ADDR_P1_FUNC, 8'h00);
    chk({18'h0, ec, irq2, oe[13]}, 21'h0);
    chk({13'h0, pull[15:8]}, 21'hf0);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
    t_reset();
    t_out0();
    t_in1();
    t_drain2();
    t_alt1();
    report_and_stop();
  end
endmodule
